// ==== logic/pmlr_pkg.sv ====
`default_nettype none
package pmlr_pkg;
  localparam int          ADDR_W       = 32;
  localparam int          DATA_W       = 32;
  localparam int          CBE_W        = 4;
  localparam int          LEN_W_DEF    = 8;
  localparam int          FIFO_DEPTH   = 8;
  localparam int          QWORD_BIT    = 2;
  localparam logic [3:0]  ST_IDLE      = 4'h0;
  localparam logic [3:0]  ST_ADDR_LOAD = 4'h1;
  localparam logic [3:0]  ST_BUS_XFER  = 4'h2;
  localparam logic [3:0]  ST_BUS_TERM  = 4'h3;
  localparam logic [1:0]  END_NONE     = 2'h0;
  localparam logic [1:0]  END_NORMAL   = 2'h1;
  typedef enum logic [2:0] {
    S_IDLE,
    S_REQ,
    S_GRANT,
    S_LOAD,
    S_ADDR,
    S_DATA,
    S_TURN
  } pmlr_fsm_t;
endpackage
`default_nettype wire

// ==== logic/pmlr_top.sv ====
// Function
// - One local quadword takes two bus phases
// - Unused half of local data reads zero
// - Half strobes say which dword moves
// - Aligned start means first dword is low
// - Bus request one cycle after local request
// - Grant on idle bus starts; local grant follows
// - Request plus grant gives address-loading status
// - Address phase drives frame, address, command, status
// - Counter loads length, drops per data phase
// - Drop bus request if wide request absent
// - Turnaround floats bus, drives enables, maybe ready
// - Devsel without ack64 clears wide indication
// - Frame stays asserted until initiator ready is given for the last phase
// - Phase completes when both ready signals low
// - Low dword: low data, low strobe only
// - Initiator ready follows previous local ready
// - High dword: high data, high strobe only
// - After last phase release, terminate normally
`timescale 1ns/1ps
`default_nettype none

module pmlr_fifo #(
  parameter int W     = 33,
  parameter int DEPTH = 8
) (
  input  wire logic                       clk,       // Clock
  input  wire logic                       sys_rst,   // Sync reset
  input  wire logic                       in_valid,  // Push request
  output logic                            in_ready,  // Room for a push
  input  wire logic [W-1:0]               in_data,   // Push data
  output logic                            out_valid, // Head is valid
  input  wire logic                       out_ready, // Pop request
  output logic [W-1:0]                    out_data,  // Head data
  output logic [$clog2(DEPTH):0]          level      // Words held
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } pmlr_fifo_t;

  pmlr_fifo_t r;
  pmlr_fifo_t n;
  logic       push;
  logic       pop;

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("pmlr_fifo: DEPTH must be a power of two, at least 2");
    end
  endgenerate

  assign in_ready  = (r.cnt != DEPTH[AW:0]);
  assign out_valid = (r.cnt != '0);
  assign out_data  = r.mem[r.rp];
  assign level     = r.cnt;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    n = r;
    if (push) begin
      n.mem[r.wp] = in_data;
      n.wp        = r.wp + 1'b1;
    end
    if (pop) begin
      n.rp = r.rp + 1'b1;
    end
    if (push && !pop) begin
      n.cnt = r.cnt + 1'b1;
    end else if (pop && !push) begin
      n.cnt = r.cnt - 1'b1;
    end
    if (sys_rst) begin
      n = '0;
    end
  end

  always_ff @(posedge clk) begin
    r <= n;
  end
endmodule // pmlr_fifo

module pmlr_top #(
  parameter int LEN_W = pmlr_pkg::LEN_W_DEF,
  parameter int DEPTH = pmlr_pkg::FIFO_DEPTH
) (
  input  wire logic                         clk,                 // Bus clock
  input  wire logic                         sys_rst,             // Sync reset
  input  wire logic                         local_req_narrow_n,  // 32-bit transfer request
  input  wire logic                         local_req_wide_n,    // 64-bit transfer request
  input  wire logic [pmlr_pkg::ADDR_W-1:0]  local_addr_in,       // Start address
  input  wire logic [pmlr_pkg::CBE_W-1:0]   local_cmd_byteen_in, // Command, then byte enables
  input  wire logic [LEN_W-1:0]             local_burst_len_in,  // Burst length in dwords
  input  wire logic                         local_ready_n,       // Local can take read data
  output logic                              local_grant_n,       // Local grant
  output logic [3:0]                        local_master_state,  // Local status code
  output logic [1:0]                        end_cause_code,      // Termination cause
  output logic [LEN_W-1:0]                  burst_remaining_count, // Phases still to run
  output logic                              wide_xfer_active_n,  // Transfer is 64-bit wide
  output logic                              low_half_xfer_n,     // Low dword strobe
  output logic                              high_half_xfer_n,    // High dword strobe
  output logic [2*pmlr_pkg::DATA_W-1:0]     local_data_out,      // Read data to local
  output logic                              pci_req_n,           // Bus request to arbiter
  input  wire logic                         pci_gnt_n,           // Bus grant
  input  wire logic                         pci_frame_n_in,      // Frame pin level
  output logic                              pci_frame_n_out,     // Frame drive value
  output logic                              pci_frame_n_oe,      // Frame driven
  input  wire logic                         pci_irdy_n_in,       // Initiator ready pin level
  output logic                              pci_irdy_n_out,      // Initiator ready drive value
  output logic                              pci_irdy_n_oe,       // Initiator ready driven
  input  wire logic                         pci_trdy_n,          // Target ready
  input  wire logic                         pci_devsel_n,        // Device select
  input  wire logic                         pci_ack64_n,         // 64-bit acknowledge
  input  wire logic [pmlr_pkg::DATA_W-1:0]  pci_ad_in,           // Address/data pin level
  output logic [pmlr_pkg::DATA_W-1:0]       pci_ad_out,          // Address/data drive value
  output logic                              pci_ad_oe,           // Address/data driven
  output logic [pmlr_pkg::CBE_W-1:0]        pci_cbe_n_out,       // Command/byte enables
  output logic                              pci_cbe_n_oe         // Command/byte enables driven
);
  import pmlr_pkg::*;

  localparam int LW = $clog2(DEPTH) + 1;

  typedef struct packed {
    pmlr_fsm_t         fsm;
    logic              req_n;
    logic              grant_n;
    logic              frame_n;
    logic              frame_oe;
    logic              irdy_n;
    logic              irdy_oe;
    logic              ad_oe;
    logic [ADDR_W-1:0] ad;
    logic              cbe_oe;
    logic [CBE_W-1:0]  cbe;
    logic [3:0]        status;
    logic [1:0]        cause;
    logic              wide_n;
    logic [LEN_W-1:0]  count;
    logic              half_hi;
  } pmlr_core_t;

  pmlr_core_t         r;
  pmlr_core_t         n;
  logic               done;
  logic               bus_idle;
  logic               room;
  logic               ask_irdy;
  logic [LEN_W-1:0]   rem;
  logic               fifo_in_ready;
  logic               fifo_out_valid;
  logic               fifo_out_ready;
  logic [DATA_W:0]    fifo_out_data;
  logic [LW-1:0]      fifo_level;
  logic [LW-1:0]      fill_after;

  generate
    // Length-one constants are built by zero-padding, so at least two bits
    if (LEN_W < 2 || LEN_W > 16) begin : g_bad_len
      $error("pmlr_top: LEN_W must lie between 2 and 16");
    end
  endgenerate

  // Bus pins share this clock, so they are read directly
  assign done     = r.irdy_oe && !r.irdy_n && !pci_trdy_n;
  assign bus_idle = pci_frame_n_in && pci_irdy_n_in;
  assign rem      = r.count - {{(LEN_W-1){1'b0}}, done};

  // A phase may complete this cycle and the next, so one slot must stay free
  assign fill_after = fifo_level + {{(LW-1){1'b0}}, done};
  assign room       = fifo_in_ready && (fill_after < DEPTH[LW-1:0]);
  assign ask_irdy   = !local_ready_n && room;

  always_comb begin
    n = r;
    unique case (r.fsm)
      S_IDLE: begin
        if (!local_req_narrow_n) begin
          n.req_n  = 1'b0;
          n.status = ST_IDLE;
          n.cause  = END_NONE;
          n.fsm    = S_REQ;
        end
      end
      S_REQ: begin
        if (local_req_narrow_n) begin
          n.req_n = 1'b1;
          n.fsm   = S_IDLE;
        end else if (!pci_gnt_n && bus_idle) begin
          n.grant_n = 1'b0;
          n.fsm     = S_GRANT;
        end
      end
      S_GRANT: begin
        n.grant_n = pci_gnt_n;
        if (local_req_narrow_n) begin
          n.req_n   = 1'b1;
          n.grant_n = 1'b1;
          n.fsm     = S_IDLE;
        end else if (pci_gnt_n) begin
          n.fsm = S_REQ;
        end else begin
          n.status = ST_ADDR_LOAD;
          n.fsm    = S_LOAD;
        end
      end
      S_LOAD: begin
        // Request fields are latched straight into the address phase drivers
        n.grant_n  = pci_gnt_n;
        n.frame_n  = 1'b0;
        n.frame_oe = 1'b1;
        n.ad       = local_addr_in;
        n.ad_oe    = 1'b1;
        n.cbe      = local_cmd_byteen_in;
        n.cbe_oe   = 1'b1;
        n.status   = ST_BUS_XFER;
        n.wide_n   = local_req_wide_n;
        // Zero length would wrap the counter into 2**LEN_W phases; it runs as one phase
        n.count    = (local_burst_len_in == '0) ? {{(LEN_W-1){1'b0}}, 1'b1}
                                                : local_burst_len_in;
        n.half_hi  = local_addr_in[QWORD_BIT];
        n.fsm      = S_ADDR;
      end
      S_ADDR: begin
        n.grant_n = pci_gnt_n;
        n.ad_oe   = 1'b0;
        n.cbe     = local_cmd_byteen_in;
        n.irdy_oe = 1'b1;
        n.irdy_n  = !ask_irdy;
        n.frame_n = ask_irdy && (r.count == {{(LEN_W-1){1'b0}}, 1'b1});
        if (local_req_wide_n) begin
          n.req_n = 1'b1;
        end
        n.fsm = S_DATA;
      end
      S_DATA: begin
        n.grant_n = pci_gnt_n;
        n.cbe     = local_cmd_byteen_in;
        if (!pci_devsel_n && pci_ack64_n) begin
          n.wide_n = 1'b1;
        end
        if (local_req_wide_n) begin
          n.req_n = 1'b1;
        end
        if (done) begin
          n.count   = rem;
          n.half_hi = !r.half_hi;
        end
        if (done && rem == '0) begin
          n.frame_n  = 1'b1;
          n.frame_oe = 1'b0;
          n.cbe_oe   = 1'b0;
          n.irdy_n   = 1'b1;
          n.req_n    = 1'b1;
          n.grant_n  = 1'b1;
          n.status   = ST_BUS_TERM;
          n.cause    = END_NORMAL;
          n.fsm      = S_TURN;
        end else begin
          // Once asserted, initiator ready holds until its phase completes
          if (!r.irdy_n && !done) begin
            n.irdy_n = 1'b0;
          end else begin
            n.irdy_n = !ask_irdy;
          end
          n.frame_n = !n.irdy_n && (rem == {{(LEN_W-1){1'b0}}, 1'b1});
        end
      end
      S_TURN: begin
        n.irdy_oe = 1'b0;
        n.irdy_n  = 1'b1;
        n.fsm     = S_IDLE;
      end
      default: begin
        n.fsm = S_IDLE;
      end
    endcase
    if (sys_rst) begin
      n          = '0;
      n.fsm      = S_IDLE;
      n.req_n    = 1'b1;
      n.grant_n  = 1'b1;
      n.frame_n  = 1'b1;
      n.irdy_n   = 1'b1;
      n.cbe      = '1;
      n.status   = ST_IDLE;
      n.cause    = END_NONE;
      n.wide_n   = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    r <= n;
  end

  // Read data waits here while the local side holds off
  pmlr_fifo #(
    .W     (DATA_W + 1),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (done),
    .in_ready  (fifo_in_ready),
    .in_data   ({r.half_hi, pci_ad_in}),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data),
    .level     (fifo_level)
  );

  assign fifo_out_ready   = !local_ready_n;
  // Strobes mark the one cycle the local side may take the word
  assign low_half_xfer_n  = !(fifo_out_valid && !local_ready_n && !fifo_out_data[DATA_W]);
  assign high_half_xfer_n = !(fifo_out_valid && !local_ready_n && fifo_out_data[DATA_W]);
  assign local_data_out   = !fifo_out_valid        ? '0 :
                            fifo_out_data[DATA_W] ? {fifo_out_data[DATA_W-1:0], {DATA_W{1'b0}}} :
                                                    {{DATA_W{1'b0}}, fifo_out_data[DATA_W-1:0]};

  assign local_grant_n         = r.grant_n;
  assign local_master_state    = r.status;
  assign end_cause_code        = r.cause;
  assign burst_remaining_count = r.count;
  assign wide_xfer_active_n    = r.wide_n;
  assign pci_req_n             = r.req_n;
  assign pci_frame_n_out       = r.frame_n;
  assign pci_frame_n_oe        = r.frame_oe;
  assign pci_irdy_n_out        = r.irdy_n;
  assign pci_irdy_n_oe         = r.irdy_oe;
  assign pci_ad_out            = r.ad;
  assign pci_ad_oe             = r.ad_oe;
  assign pci_cbe_n_out         = r.cbe;
  assign pci_cbe_n_oe          = r.cbe_oe;
endmodule // pmlr_top

`default_nettype wire

// ==== testbench/pmlr_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module pmlr_assertions
  import pmlr_pkg::*;
#(
  parameter int LEN_W = 8
) (
  input wire logic             clk,                   // Clock
  input wire logic             sys_rst,               // Reset
  input wire logic             local_req_narrow_n,    // Request
  input wire logic             local_req_wide_n,      // Wide request
  input wire logic             local_ready_n,         // Ready
  input wire logic             local_grant_n,         // Grant
  input wire logic [3:0]       local_master_state,    // Status
  input wire logic [1:0]       end_cause_code,        // Cause
  input wire logic [LEN_W-1:0] burst_remaining_count, // Count
  input wire logic             low_half_xfer_n,       // Low strobe
  input wire logic             high_half_xfer_n,      // High strobe
  input wire logic [63:0]      local_data_out,        // Data
  input wire logic             pci_req_n,             // Bus request
  input wire logic             pci_gnt_n,             // Bus grant
  input wire logic             pci_frame_n_out,       // Frame
  input wire logic             pci_irdy_n_out,        // Irdy
  input wire logic             pci_irdy_n_oe,         // Irdy enable
  input wire logic             pci_trdy_n,            // Trdy
  input wire logic             pci_ad_oe              // Bus enable
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  req_follow_a: assert property (
    local_master_state == ST_IDLE && !local_req_narrow_n && pci_req_n |=> !pci_req_n) else $error("late bus req");
  load_status_a: assert property (
    $fell(local_grant_n) && !local_req_narrow_n && !pci_gnt_n |=> local_master_state == ST_ADDR_LOAD) else $error("no load");
  grant_follow_a: assert property (
    !local_grant_n && pci_gnt_n |=> local_grant_n) else $error("grant stuck");
  turn_cycle_a: assert property (
    local_master_state == ST_ADDR_LOAD |=> ##1 !pci_ad_oe && pci_irdy_n_oe && pci_irdy_n_out == $past(local_ready_n))
    else $error("bad turnaround");
  count_step_a: assert property (
    !pci_irdy_n_out && pci_irdy_n_oe && !pci_trdy_n |=> burst_remaining_count == $past(burst_remaining_count) - 1'h1)
    else $error("count step");
  last_phase_a: assert property (
    !pci_irdy_n_out && pci_irdy_n_oe && !pci_trdy_n && pci_frame_n_out |=> local_master_state == ST_BUS_TERM
    && end_cause_code == END_NORMAL && pci_irdy_n_out ##1 !pci_irdy_n_oe) else $error("bad end");
  low_half_a: assert property (
    !low_half_xfer_n |-> high_half_xfer_n && local_data_out[63:32] == 32'h0 && !local_ready_n) else $error("low half");
  high_half_a: assert property (
    !high_half_xfer_n |-> low_half_xfer_n && local_data_out[31:0] == 32'h0 && !local_ready_n) else $error("high half");
  req_drop_a: assert property (
    $fell(pci_frame_n_out) && local_req_wide_n |=> pci_req_n) else $error("bus req held");
endmodule // pmlr_assertions

bind pmlr_top pmlr_assertions #(.LEN_W(LEN_W)) chk_u (
  .clk                   (clk),
  .sys_rst               (sys_rst),
  .local_req_narrow_n    (local_req_narrow_n),
  .local_req_wide_n      (local_req_wide_n),
  .local_ready_n         (local_ready_n),
  .local_grant_n         (local_grant_n),
  .local_master_state    (local_master_state),
  .end_cause_code        (end_cause_code),
  .burst_remaining_count (burst_remaining_count),
  .low_half_xfer_n       (low_half_xfer_n),
  .high_half_xfer_n      (high_half_xfer_n),
  .local_data_out        (local_data_out),
  .pci_req_n             (pci_req_n),
  .pci_gnt_n             (pci_gnt_n),
  .pci_frame_n_out       (pci_frame_n_out),
  .pci_irdy_n_out        (pci_irdy_n_out),
  .pci_irdy_n_oe         (pci_irdy_n_oe),
  .pci_trdy_n            (pci_trdy_n),
  .pci_ad_oe             (pci_ad_oe)
);
`default_nettype wire

// ==== testbench/pmlr_target_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module pmlr_target_model #(
  parameter logic [31:0] DBASE = 32'h0
) (
  input  wire logic        clk,            // Clock
  input  wire logic        sys_rst,        // Reset
  input  wire logic        slow,           // Wait states
  input  wire logic        pci_req_n,      // Request
  input  wire logic        pci_frame_n_in, // Frame pin
  input  wire logic        pci_irdy_n_in,  // Irdy pin
  output logic             pci_gnt_n,      // Grant
  output logic             pci_trdy_n,     // Target ready
  output logic             pci_devsel_n,   // Select
  output logic             pci_ack64_n,    // Wide ack
  output logic [31:0]      tgt_ad          // Data
);
  logic [31:0] n;
  wire logic   done = !pci_irdy_n_in && !pci_trdy_n;
  assign pci_ack64_n = 1'h1; // Narrow target only
  // Off-phase data is inverted so a stale sample cannot match
  assign tgt_ad = pci_trdy_n ? ~(DBASE + n) : DBASE + n;
  always_ff @(posedge clk) begin
    pci_gnt_n <= sys_rst | pci_req_n;
    n         <= sys_rst ? 32'h0 : n + {31'h0, done};
    if (sys_rst) begin
      pci_devsel_n <= 1'h1;
      pci_trdy_n   <= 1'h1;
    end else if (pci_devsel_n) begin
      pci_devsel_n <= pci_frame_n_in | !pci_irdy_n_in; // Claim on address phase
    end else if (done && pci_frame_n_in) begin
      pci_devsel_n <= 1'h1;
      pci_trdy_n   <= 1'h1;
    end else if (pci_trdy_n || done) begin
      pci_trdy_n   <= slow & !pci_trdy_n; // Held until taken
    end
  end
endmodule // pmlr_target_model
`default_nettype wire

// ==== testbench/pmlr_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module pmlr_top_tb;
  import pmlr_pkg::*;
  localparam logic [31:0] DBASE = 32'h5A00_0000;
  logic        clk, sys_rst, local_req_narrow_n, local_req_wide_n, local_ready_n, slow, local_grant_n;
  logic        wide_xfer_active_n, low_half_xfer_n, high_half_xfer_n, pci_req_n, pci_gnt_n, pci_trdy_n;
  logic        pci_frame_n_in, pci_frame_n_out, pci_frame_n_oe, pci_irdy_n_in, pci_irdy_n_out, pci_irdy_n_oe;
  logic        pci_devsel_n, pci_ack64_n, pci_ad_oe, pci_cbe_n_oe;
  logic [1:0]  end_cause_code;
  logic [3:0]  local_cmd_byteen_in, local_master_state, pci_cbe_n_out;
  logic [7:0]  local_burst_len_in, burst_remaining_count;
  logic [31:0] local_addr_in, pci_ad_in, pci_ad_out, tgt_ad, nxt;
  logic [63:0] local_data_out;
  int          n_fail, checks_done;

  assign pci_frame_n_in = !pci_frame_n_oe | pci_frame_n_out; // Pulled up when released
  assign pci_irdy_n_in  = !pci_irdy_n_oe | pci_irdy_n_out;
  assign pci_ad_in      = pci_ad_oe ? pci_ad_out : tgt_ad;
  pmlr_top #(.LEN_W(8), .DEPTH(8)) dut_u (.*);
  pmlr_target_model #(.DBASE(DBASE)) tgt_u (.*);

  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic results;
    if (n_fail == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  task automatic burst(input logic [31:0] a, input int len, input int hold, input int gap);
    int          k;
    int          t;
    logic        h;
    logic [31:0] qa;
    h = a[2];
    k = 0;
    t = 0;
    qa = {a[31:3], 3'h0};
    local_addr_in = a;
    local_burst_len_in = 8'(len);
    local_cmd_byteen_in = 4'h6;
    local_req_narrow_n = 1'h0;
    while (local_master_state !== ST_ADDR_LOAD && t++ < 40) tick(1);
    chk("load status", local_master_state, ST_ADDR_LOAD);
    chk("grant", local_grant_n, 1'h0);
    // Command and request stand through the address-loading cycle
    tick(1);
    chk("addr phase", {pci_frame_n_out, pci_frame_n_oe, pci_ad_oe, pci_cbe_n_oe}, 4'h7);
    chk("addr", pci_ad_out, a);
    chk("cmd", pci_cbe_n_out, 4'h6);
    chk("xfer status", local_master_state, ST_BUS_XFER);
    local_req_narrow_n = 1'h1;
    local_cmd_byteen_in = 4'h0;
    repeat (hold) tick(1);
    chk("waiting count", burst_remaining_count, 8'(len));
    chk("waiting irdy", pci_irdy_n_out, 1'h1);
    local_ready_n = 1'h0;
    while (k < len && t++ < 200) begin
      @(negedge clk);
      if (!low_half_xfer_n || !high_half_xfer_n) begin
        chk("low strobe", low_half_xfer_n, h);
        chk("high strobe", high_half_xfer_n, !h);
        chk("data", local_data_out, h ? {nxt, 32'h0} : {32'h0, nxt});
        chk("narrow", wide_xfer_active_n, 1'h1);
        if (h) begin
          qa += 32'h8;
        end
        nxt++;
        k++;
        h = !h;
      end
      tick(1);
      // Gaps make the read data wait in the buffer
      if (gap != 0) begin
        local_ready_n = (t % 3 == 1);
      end
    end
    chk("words", k, len);
    chk("quadword addr", qa, (a + 32'(4 * len)) & ~32'h7);
    chk("status", local_master_state, ST_BUS_TERM);
    chk("cause", end_cause_code, END_NORMAL);
    chk("count", burst_remaining_count, 8'h0);
    local_ready_n = 1'h1;
    tick(2);
  endtask

  task automatic t_reset_state;
    chk("reset flags", {pci_req_n, local_grant_n, wide_xfer_active_n, low_half_xfer_n, high_half_xfer_n,
      pci_frame_n_oe, pci_irdy_n_oe, pci_ad_oe, pci_cbe_n_oe}, 9'h1F0);
    chk("reset codes", {local_master_state, end_cause_code, burst_remaining_count, pci_cbe_n_out},
      {ST_IDLE, END_NONE, 8'h0, 4'hF});
    chk("reset data", local_data_out, 64'h0);
  endtask

  task automatic t_refused;
    local_req_narrow_n = 1'h0;
    tick(2);
    local_req_narrow_n = 1'h1;
    tick(12);
    chk("refused req", pci_req_n, 1'h1);
    chk("refused frame", pci_frame_n_oe, 1'h0);
  endtask

  task automatic t_aligned;
    burst(32'h0000_1000, 4, 0, 0);
  endtask

  task automatic t_unaligned_slow;
    slow = 1'h1;
    local_req_wide_n = 1'h0;
    burst(32'h0000_2004, 5, 0, 0);
    slow = 1'h0;
    local_req_wide_n = 1'h1;
  endtask

  task automatic t_stall;
    burst(32'h0000_3008, 3, 6, 0);
  endtask

  task automatic t_backlog;
    burst(32'h0000_4000, 6, 0, 1);
  endtask

  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  initial begin
    {sys_rst, local_req_narrow_n, local_req_wide_n, local_ready_n} = 4'hF;
    slow = 1'h0;
    local_addr_in = 32'h0;
    local_cmd_byteen_in = 4'h0;
    local_burst_len_in = 8'h0;
    nxt = DBASE;
    n_fail = 0;
    checks_done = 0;
    tick(8);
    sys_rst = 1'h0;
    tick(1);
    t_reset_state;
    t_refused;
    t_aligned;
    t_unaligned_slow;
    t_stall;
    t_backlog;
    results;
  end

  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    results;
  end
endmodule // pmlr_top_tb
`default_nettype wire
